// [core/calc_pkg.sv]
package calc_pkg;
  // operand and frame geometry
  localparam int DW = 32;
  localparam int FRAME_LEN = 9;
  localparam int VAR_COUNT = 256;
  localparam logic [3:0] LAST_BYTE = 4'h8;
  // byte positions inside a command frame
  localparam logic [3:0] POS_ADDR = 4'h0;
  localparam logic [3:0] POS_CMD = 4'h1;
  localparam logic [3:0] POS_TYPE = 4'h2;
  localparam logic [3:0] POS_BANK = 4'h3;
  localparam logic [3:0] POS_SUM = 4'h8;
  // addresses carried in frames
  localparam logic [7:0] MODULE_ADDR = 8'h01;
  localparam logic [7:0] HOST_ADDR = 8'h02;
  // instruction codes handled here
  localparam logic [7:0] CMD_VAR_ACC = 8'h29;
  localparam logic [7:0] CMD_ACC_VAR = 8'h2a;
  localparam logic [7:0] CMD_VAR_X = 8'h2b;
  // reply status codes
  localparam logic [7:0] ST_OK = 8'h64;
  localparam logic [7:0] ST_BAD_SUM = 8'h01;
  localparam logic [7:0] ST_BAD_CMD = 8'h02;
  localparam logic [7:0] ST_BAD_TYPE = 8'h03;
  // operation selected by the type byte
  localparam logic [3:0] OP_ADD = 4'h0;
  localparam logic [3:0] OP_SUB = 4'h1;
  localparam logic [3:0] OP_MUL = 4'h2;
  localparam logic [3:0] OP_DIV = 4'h3;
  localparam logic [3:0] OP_MOD = 4'h4;
  localparam logic [3:0] OP_AND = 4'h5;
  localparam logic [3:0] OP_OR = 4'h6;
  localparam logic [3:0] OP_XOR = 4'h7;
  localparam logic [3:0] OP_NOT = 4'h8;
  localparam logic [3:0] OP_LOAD = 4'h9;
  localparam logic [3:0] OP_SWAP = 4'ha;
  localparam logic [3:0] OP_COMP = 4'hb;
  localparam logic [7:0] TYPE_MAX = 8'h0b;
  // reset values
  localparam logic [31:0] ACC_RST = 32'h0000_0000;
  localparam logic [31:0] X_RST = 32'h0000_0000;
  localparam logic [31:0] VAR_RST = 32'h0000_0000;
  localparam logic [7:0] STATUS_RST = 8'h00;
  // divider steps, one quotient bit per cycle
  localparam logic [5:0] DIV_LAST = 6'h1f;

  // low eight bits of the sum of the first eight bytes
  function automatic logic [7:0] frame_sum(input logic [7:0] b [FRAME_LEN]);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < FRAME_LEN - 1; i++) begin
      s = s + b[i];
    end
    return s;
  endfunction : frame_sum
endpackage : calc_pkg

// [core/calc_alu.sv]
`timescale 1ns/10ps
module calc_alu
  import calc_pkg::*;
(
  input wire logic [3:0] i_op,
  input wire logic [DW-1:0] i_a,
  input wire logic [DW-1:0] i_b,
  output logic [DW-1:0] o_res,
  output logic o_wr_dst,
  output logic o_wr_src,
  output logic o_is_div,
  output logic o_eq,
  output logic o_lt
);

  ////////////////////////////////////////////////////////////////////////
  // compare flags, signed 32-bit view of both operands
  assign o_eq = (i_a == i_b);
  assign o_lt = ($signed(i_a) < $signed(i_b));

  ////////////////////////////////////////////////////////////////////////
  // single-cycle operations; divide and modulo go to the divider
  always_comb begin
    o_res = i_a;
    o_wr_dst = 1'b1;
    o_wr_src = 1'b0;
    o_is_div = 1'b0;
    unique case (i_op)
      OP_ADD: o_res = i_a + i_b;
      OP_SUB: o_res = i_a - i_b;
      OP_MUL: o_res = i_a * i_b; // low word of the product
      OP_DIV, OP_MOD: begin
        o_is_div = 1'b1; // result taken from the divider
      end
      OP_AND: o_res = i_a & i_b;
      OP_OR: o_res = i_a | i_b;
      OP_XOR: o_res = i_a ^ i_b;
      OP_NOT: o_res = ~i_b;
      OP_LOAD: o_res = i_b;
      OP_SWAP: begin
        o_res = i_b; // the other operand gets the old i_a
        o_wr_src = 1'b1;
      end
      OP_COMP: o_wr_dst = 1'b0; // flags only
      default: o_wr_dst = 1'b0; // illegal type, nothing written
    endcase
  end
endmodule : calc_alu

// [core/calc_div.sv]
`timescale 1ns/10ps
module calc_div
  import calc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic [DW-1:0] i_num,
  input wire logic [DW-1:0] i_den,
  output logic o_done,
  output logic [DW-1:0] o_quot,
  output logic [DW-1:0] o_rem
);

  logic busy_q; // iteration in progress
  logic [5:0] cnt_q; // quotient bit index
  logic [DW:0] r_q; // partial remainder
  logic [DW-1:0] q_q; // quotient shifter, holds dividend at start
  logic [DW-1:0] d_q; // divisor magnitude
  logic qneg_q; // quotient takes a minus sign
  logic rneg_q; // remainder follows the dividend sign

  // magnitude of a signed word
  function automatic logic [DW-1:0] mag(input logic [DW-1:0] v);
    return v[DW-1] ? -v : v;
  endfunction : mag

  ////////////////////////////////////////////////////////////////////////
  // one restoring step
  wire [DW:0] r_sh = {r_q[DW-1:0], q_q[DW-1]};
  wire [DW:0] diff = r_sh - {1'b0, d_q};
  wire [DW:0] r_nx = diff[DW] ? r_sh : diff;
  wire [DW-1:0] q_nx = {q_q[DW-2:0], ~diff[DW]};

  ////////////////////////////////////////////////////////////////////////
  // iteration and sign correction at the last step
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      busy_q <= 1'b0;
      cnt_q <= 6'h00;
      r_q <= '0;
      q_q <= '0;
      d_q <= '0;
      qneg_q <= 1'b0;
      rneg_q <= 1'b0;
      o_done <= 1'b0;
      o_quot <= '0;
      o_rem <= '0;
    end else begin
      o_done <= 1'b0;
      if (i_start) begin
        busy_q <= 1'b1;
        cnt_q <= 6'h00;
        r_q <= '0;
        q_q <= mag(i_num);
        d_q <= mag(i_den);
        qneg_q <= i_num[DW-1] ^ i_den[DW-1];
        rneg_q <= i_num[DW-1];
      end else if (busy_q) begin
        r_q <= r_nx;
        q_q <= q_nx;
        cnt_q <= cnt_q + 6'h01;
        if (cnt_q == DIV_LAST) begin
          busy_q <= 1'b0;
          o_done <= 1'b1;
          o_quot <= qneg_q ? -q_nx : q_nx;
          o_rem <= rneg_q ? -r_nx[DW-1:0] : r_nx[DW-1:0];
        end
      end
    end
  end
endmodule : calc_div

// [core/calc_exec_top.sv]
`timescale 1ns/10ps
// Notes on behaviour
// RULE1: code 0x29 type 1: variable minus accumulator
// RULE2: host sends nine bytes, value MSB first
// RULE3: reply nine bytes, success status 0x64
// RULE4: code 42 result goes to accumulator
// RULE5: bank byte indexes variable; value ignored
// RULE6: code 42 types 0-4 arithmetic
// RULE7: code 42 types 5-9 logic, invert, copy
// RULE8: code 42 type 10 swap, 11 compare
// RULE9: code 0x2A type 1: accumulator minus variable
// RULE10: code 43 result goes to variable
// RULE11: code 43 type 0 add, 1 subtract
// RULE12: code 43 types 2-7 and swap
// RULE13: code 43 type 8 invert, 11 compare
// RULE14: code 43 type 9 copies X
// RULE15: reply status 100 after success
// RULE16: code 41 result goes to variable
// RULE17: checksum is low byte of sum
// RULE18: operands and results are 32 bits
module calc_exec_top
  import calc_pkg::*;
(
  input wire logic I_MCLK,
  input wire logic I_RST,
  input wire logic [7:0] I_RX_DATA,
  input wire logic I_RX_VALID,
  output logic O_RX_READY,
  output logic [7:0] O_TX_DATA,
  output logic O_TX_VALID,
  input wire logic I_TX_READY,
  input wire logic I_ACC_WE,
  input wire logic [DW-1:0] I_ACC_WDATA,
  input wire logic I_X_WE,
  input wire logic [DW-1:0] I_X_WDATA,
  input wire logic [7:0] I_VAR_IDX,
  output logic [DW-1:0] O_VAR_DATA,
  output logic [DW-1:0] O_ACC,
  output logic [DW-1:0] O_XREG,
  output logic O_CMP_EQ,
  output logic O_CMP_LT
);

  // receive, execute, wait on the divider, send the reply
  typedef enum logic [1:0] {S_RECV, S_EXEC, S_DIV, S_REPLY} state_t;

  state_t state_q; // frame sequencer
  logic [3:0] cnt_q; // byte index in current frame
  logic [7:0] frame_q [FRAME_LEN]; // received command bytes
  logic [7:0] status_q; // status for the reply
  logic [DW-1:0] acc_q; // accumulator
  logic [DW-1:0] x_q; // X register
  logic [DW-1:0] var_q [VAR_COUNT]; // user variables
  logic cmp_eq_q; // last compare: equal
  logic cmp_lt_q; // last compare: destination below source
  logic [DW-1:0] var_rd_q; // read port data
  logic [7:0] tx_data_q; // registered reply byte

  ////////////////////////////////////////////////////////////////////////
  // field decoding of the held frame
  wire [7:0] cmd = frame_q[POS_CMD]; // [RULE2]
  wire [7:0] type_b = frame_q[POS_TYPE];
  wire [3:0] op = type_b[3:0];
  wire [7:0] idx = frame_q[POS_BANK]; // [RULE5]
  wire [7:0] rx_sum = frame_sum(frame_q);
  wire sum_ok = (rx_sum == frame_q[POS_SUM]); // [RULE17]
  wire addr_ok = (frame_q[POS_ADDR] == MODULE_ADDR);
  wire is_va = (cmd == CMD_VAR_ACC); // [RULE16]
  wire is_av = (cmd == CMD_ACC_VAR); // [RULE4]
  wire is_vx = (cmd == CMD_VAR_X); // [RULE10]
  wire cmd_ok = is_va | is_av | is_vx;
  wire type_ok = (type_b <= TYPE_MAX);
  wire exec_ok = sum_ok & cmd_ok & type_ok;

  ////////////////////////////////////////////////////////////////////////
  // operand selection; value bytes never reach the datapath
  wire [DW-1:0] var_cur = var_q[idx]; // [RULE5]
  // destination: accumulator for code 42, else the variable
  wire [DW-1:0] opa = is_av ? acc_q : var_cur; // [RULE4] [RULE10]
  // source: accumulator, variable or X by code
  wire [DW-1:0] opb = is_va ? acc_q : (is_av ? var_cur : x_q); // [RULE18]

  wire [DW-1:0] alu_res;
  wire alu_wr_dst;
  wire alu_wr_src;
  wire alu_is_div;
  wire alu_eq;
  wire alu_lt;
  wire div_done;
  wire [DW-1:0] div_quot;
  wire [DW-1:0] div_rem;

  ////////////////////////////////////////////////////////////////////////
  // single-cycle operations of all three codes
  // [RULE1] [RULE6] [RULE7] [RULE8] [RULE9]
  // [RULE11] [RULE12] [RULE13] [RULE14]
  calc_alu u_alu (
    .i_op(op),
    .i_a(opa),
    .i_b(opb),
    .o_res(alu_res),
    .o_wr_dst(alu_wr_dst),
    .o_wr_src(alu_wr_src),
    .o_is_div(alu_is_div),
    .o_eq(alu_eq),
    .o_lt(alu_lt)
  );

  ////////////////////////////////////////////////////////////////////////
  // divide and modulo; a zero divisor skips the divider
  wire div_zero = (opb == '0);
  wire div_start = (state_q == S_EXEC) & addr_ok & exec_ok & alu_is_div
                   & ~div_zero;

  calc_div u_div (
    .i_clk(I_MCLK),
    .i_rst(I_RST),
    .i_start(div_start),
    .i_num(opa),
    .i_den(opb),
    .o_done(div_done),
    .o_quot(div_quot),
    .o_rem(div_rem)
  );

  ////////////////////////////////////////////////////////////////////////
  // commit strobe and write-back routing
  wire exec_now = (state_q == S_EXEC) & addr_ok & exec_ok & ~div_start;
  wire commit = exec_now | ((state_q == S_DIV) & div_done);
  wire [DW-1:0] div_res = (op == OP_DIV) ? div_quot : div_rem; // [RULE6]
  wire [DW-1:0] fin_res = alu_is_div ? div_res : alu_res;
  // a zero divisor commits at once but blocks the destination write
  wire dst_we = commit & alu_wr_dst & ~(alu_is_div & div_zero);
  wire src_we = commit & alu_wr_src; // swap only
  // variable is destination for codes 41/43, swap source for 42
  wire var_we = is_av ? src_we : dst_we; // [RULE1] [RULE10] [RULE16]
  wire [DW-1:0] var_wd = is_av ? opa : fin_res; // [RULE8]
  // accumulator is destination for 42, swap source for 41
  wire acc_we = is_av ? dst_we : (src_we & is_va); // [RULE4] [RULE9]
  wire [DW-1:0] acc_wd = is_av ? fin_res : opa;
  // calculation changes the X register only by swap under code 43
  wire x_we = src_we & is_vx; // [RULE12]
  wire cmp_we = commit & (op == OP_COMP); // [RULE8] [RULE13]
  // host may load the registers only while idle
  wire host_ok = (state_q == S_RECV);

  ////////////////////////////////////////////////////////////////////////
  // status decision in the execute cycle
  wire [7:0] status_d = ~sum_ok ? ST_BAD_SUM :
                        ~cmd_ok ? ST_BAD_CMD :
                        ~type_ok ? ST_BAD_TYPE : ST_OK; // [RULE15]

  ////////////////////////////////////////////////////////////////////////
  // reply bytes; value field is always zero
  logic [7:0] reply_b [FRAME_LEN];
  assign reply_b[0] = HOST_ADDR; // [RULE3]
  assign reply_b[1] = MODULE_ADDR;
  assign reply_b[2] = status_q;
  assign reply_b[3] = cmd;
  assign reply_b[4] = 8'h00;
  assign reply_b[5] = 8'h00;
  assign reply_b[6] = 8'h00;
  assign reply_b[7] = 8'h00;
  assign reply_b[8] = 8'h00;
  wire [7:0] tx_sum = frame_sum(reply_b); // [RULE17]

  ////////////////////////////////////////////////////////////////////////
  // byte handshakes
  wire rx_take = (state_q == S_RECV) & I_RX_VALID;
  wire tx_take = (state_q == S_REPLY) & I_TX_READY;
  assign O_RX_READY = (state_q == S_RECV);
  assign O_TX_VALID = (state_q == S_REPLY);
  assign O_TX_DATA = tx_data_q; // [RULE3]
  assign O_ACC = acc_q;
  assign O_XREG = x_q;
  assign O_CMP_EQ = cmp_eq_q;
  assign O_CMP_LT = cmp_lt_q;
  assign O_VAR_DATA = var_rd_q;

  ////////////////////////////////////////////////////////////////////////
  // reply byte register: byte 0 loads in the execute cycle, the next
  // byte on every take, so the pin is a flop and never a live mux
  wire [3:0] tx_nxt = (cnt_q == LAST_BYTE) ? 4'h0 : cnt_q + 4'h1;
  wire [7:0] tx_byte_nxt = (tx_nxt == POS_SUM) ? tx_sum : reply_b[tx_nxt];
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      tx_data_q <= HOST_ADDR; // byte 0 shows while idle
    end else if (state_q == S_EXEC) begin
      tx_data_q <= HOST_ADDR; // first reply byte [RULE3]
    end else if (tx_take) begin
      tx_data_q <= tx_byte_nxt; // advance on each take [RULE3]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // frame sequencer
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      state_q <= S_RECV;
      cnt_q <= 4'h0;
      status_q <= STATUS_RST;
    end else begin
      unique case (state_q)
        S_RECV: begin
          if (rx_take) begin
            // ninth byte closes the frame
            cnt_q <= (cnt_q == LAST_BYTE) ? 4'h0 : cnt_q + 4'h1; // [RULE2]
            if (cnt_q == LAST_BYTE) begin
              state_q <= S_EXEC;
            end
          end
        end
        S_EXEC: begin
          // latched even for a dropped frame; then it is never sent
          status_q <= status_d;
          if (~addr_ok) begin
            state_q <= S_RECV; // frame for another unit, no reply
          end else if (div_start) begin
            state_q <= S_DIV;
          end else begin
            state_q <= S_REPLY;
          end
        end
        S_DIV: begin
          // operands hold still: frame and registers are frozen
          if (div_done) begin
            state_q <= S_REPLY;
          end
        end
        S_REPLY: begin
          if (tx_take) begin
            cnt_q <= (cnt_q == LAST_BYTE) ? 4'h0 : cnt_q + 4'h1; // [RULE3]
            if (cnt_q == LAST_BYTE) begin
              state_q <= S_RECV;
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // frame byte capture
  // bytes land at the running index, which then serves the reply
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      for (int i = 0; i < FRAME_LEN; i++) begin
        frame_q[i] <= 8'h00;
      end
    end else if (rx_take) begin
      frame_q[cnt_q] <= I_RX_DATA; // [RULE2]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // accumulator and X register; calculation beats host load
  // host loads are dropped, not queued, while a frame is busy
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      acc_q <= ACC_RST;
      x_q <= X_RST;
    end else begin
      if (acc_we) begin
        acc_q <= acc_wd; // [RULE4] [RULE9]
      end else if (host_ok & I_ACC_WE) begin
        acc_q <= I_ACC_WDATA;
      end
      if (x_we) begin
        x_q <= opa; // [RULE12]
      end else if (host_ok & I_X_WE) begin
        x_q <= I_X_WDATA;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // compare flags and variable read port
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      cmp_eq_q <= 1'b0;
      cmp_lt_q <= 1'b0;
      var_rd_q <= VAR_RST;
    end else begin
      if (cmp_we) begin
        cmp_eq_q <= alu_eq; // [RULE8] [RULE13]
        cmp_lt_q <= alu_lt;
      end
      var_rd_q <= var_q[I_VAR_IDX];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // user variable store, one word per index
  // only the addressed word loads; the rest keep their value
  for (genvar g = 0; g < VAR_COUNT; g++) begin : g_var
    always_ff @(posedge I_MCLK or posedge I_RST) begin
      if (I_RST) begin
        var_q[g] <= VAR_RST;
      end else if (var_we && idx == 8'(g)) begin
        var_q[g] <= var_wd; // [RULE1] [RULE14] [RULE16]
      end
    end
  end
endmodule : calc_exec_top

// [dv/calc_exec_top_assertions.sv]
`timescale 1ns/10ps
module calc_exec_top_assertions
  import calc_pkg::*;
(
  input wire logic I_MCLK,
  input wire logic I_RST,
  input wire logic O_RX_READY,
  input wire logic [7:0] O_TX_DATA,
  input wire logic O_TX_VALID,
  input wire logic I_TX_READY,
  input wire logic I_ACC_WE,
  input wire logic [DW-1:0] I_ACC_WDATA,
  input wire logic I_X_WE,
  input wire logic [DW-1:0] I_X_WDATA,
  input wire logic [DW-1:0] O_ACC,
  input wire logic [DW-1:0] O_XREG,
  input wire logic O_CMP_EQ,
  input wire logic O_CMP_LT
);
  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (I_RST);
  // reply bytes already taken by the sink
  logic [3:0] taken_q;
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) taken_q <= 4'h0;
    else if (O_RX_READY) taken_q <= 4'h0;
    else if (O_TX_VALID && I_TX_READY) taken_q <= taken_q + 4'h1;
  end
  ////////////////////////////////////////////////////////////////////////////
  a_idle_exclusive: assert property (!(O_RX_READY && O_TX_VALID))
    else $error("ready and reply valid together");
  a_reply_hold: assert property (O_TX_VALID && !I_TX_READY
    |=> O_TX_VALID && $stable(O_TX_DATA)) else $error("reply byte moved");
  a_host_first: assert property ($rose(O_TX_VALID)
    |-> O_TX_DATA == HOST_ADDR) else $error("first reply byte wrong");
  a_target_second: assert property (O_TX_VALID && taken_q == 4'h1
    |-> O_TX_DATA == MODULE_ADDR) else $error("second reply byte wrong");
  a_value_zero: assert property (O_TX_VALID
    && taken_q inside {[4:7]} |-> O_TX_DATA == 8'h00)
    else $error("reply value not zero");
  a_reply_end: assert property (O_TX_VALID && I_TX_READY
    && taken_q == 4'h8 |=> O_RX_READY)
    else $error("no return to ready after nine bytes");
  a_answer_bound: assert property ($fell(O_RX_READY)
    |-> ##[1:40] (O_TX_VALID || O_RX_READY)) else $error("frame not answered");
  a_acc_load: assert property (I_ACC_WE && O_RX_READY
    |=> O_ACC == $past(I_ACC_WDATA)) else $error("accumulator load lost");
  a_x_load: assert property (I_X_WE && O_RX_READY
    |=> O_XREG == $past(I_X_WDATA)) else $error("x register load lost");
  a_regs_quiet: assert property (O_TX_VALID
    |=> $stable(O_ACC) && $stable(O_XREG)) else $error("write during reply");
  a_flags_idle: assert property (O_RX_READY
    |=> $stable(O_CMP_EQ) && $stable(O_CMP_LT))
    else $error("flags moved idle");
endmodule : calc_exec_top_assertions

// [dv/calc_host_model.sv]
`timescale 1ns/10ps
module calc_host_model (
  input wire logic i_clk,
  output logic [7:0] o_rx_data,
  output logic o_rx_valid,
  input wire logic i_rx_ready,
  input wire logic [7:0] i_tx_data,
  input wire logic i_tx_valid,
  output logic o_tx_ready
);
  logic tmo = 1'b0; // a bounded wait ran out
  initial begin
    o_rx_data = 8'h00;
    o_rx_valid = 1'b0;
    o_tx_ready = 1'b0;
  end
  // nine bytes, address first, value msb first, sum last
  task automatic send(input logic [71:0] f);
    int n;
    for (int i = 0; i < 9; i++) begin
      @(negedge i_clk);
      o_rx_data = f[71-8*i -: 8];
      o_rx_valid = 1'b1;
      n = 0;
      do begin
        @(posedge i_clk);
        n++;
      end while (!i_rx_ready && n < 60);
      if (n >= 60) tmo = 1'b1;
    end
    @(negedge i_clk);
    o_rx_valid = 1'b0;
    o_rx_data = ~o_rx_data; // released line shows no stale byte
  endtask : send
  // collect nine reply bytes, stalling every other cycle when slow
  task automatic recv(input bit slow, output logic [71:0] r);
    int k;
    k = 0;
    r = 72'h0;
    for (int n = 0; n < 200 && k < 9; n++) begin
      @(negedge i_clk);
      o_tx_ready = !slow || (n % 2 == 1);
      @(posedge i_clk);
      if (i_tx_valid && o_tx_ready) begin
        r[71-8*k -: 8] = i_tx_data;
        k++;
      end
    end
    @(negedge i_clk);
    o_tx_ready = 1'b0;
    if (k < 9) tmo = 1'b1;
  endtask : recv
endmodule : calc_host_model

// [dv/variable_accumulator_alu_ops_tb_top.sv]
`timescale 1ns/10ps
module variable_accumulator_alu_ops_tb_top import calc_pkg::*;;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic acc_we = 1'b0;
  logic x_we = 1'b0;
  logic [31:0] acc_wd = 32'h0;
  logic [31:0] x_wd = 32'h0;
  logic [7:0] var_idx = 8'h00;
  logic [7:0] rx_data, tx_data;
  logic rx_valid, rx_ready, tx_valid, tx_ready, cmp_eq, cmp_lt;
  logic [31:0] var_data, acc, xreg;
  int n_fail = 0;
  int comparisons = 0;
  calc_exec_top u_calc_exec_top (
    .I_MCLK(clk), .I_RST(rst), .I_RX_DATA(rx_data), .I_RX_VALID(rx_valid),
    .O_RX_READY(rx_ready), .O_TX_DATA(tx_data), .O_TX_VALID(tx_valid),
    .I_TX_READY(tx_ready), .I_ACC_WE(acc_we), .I_ACC_WDATA(acc_wd),
    .I_X_WE(x_we), .I_X_WDATA(x_wd), .I_VAR_IDX(var_idx),
    .O_VAR_DATA(var_data), .O_ACC(acc), .O_XREG(xreg),
    .O_CMP_EQ(cmp_eq), .O_CMP_LT(cmp_lt)
  );
  calc_host_model u_calc_host_model (
    .i_clk(clk), .o_rx_data(rx_data), .o_rx_valid(rx_valid),
    .i_rx_ready(rx_ready), .i_tx_data(tx_data), .i_tx_valid(tx_valid),
    .o_tx_ready(tx_ready)
  );
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  task automatic chk_word(input string nm, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_word
  task automatic chk_frame(input string nm, input logic [71:0] e, g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_frame
  task automatic chk_bit(input string nm, input logic e, g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit
  // eight header bytes plus low byte of their sum, skewed by ds
  function automatic logic [71:0] mkf(input logic [7:0] ad, c, t, ix,
    input logic [31:0] v, input logic [7:0] ds);
    logic [63:0] h;
    logic [7:0] s;
    h = {ad, c, t, ix, v};
    s = ds;
    for (int i = 0; i < 8; i++) s += h[8*i +: 8];
    return {h, s};
  endfunction : mkf
  // expected destination value; compare keeps it
  function automatic logic [31:0] alu(input logic [3:0] op,
    input logic [31:0] d, s);
    case (op)
      OP_ADD: return d + s;
      OP_SUB: return d - s;
      OP_MUL: return d * s;
      OP_DIV: return (s == 0) ? d : 32'($signed(d) / $signed(s));
      OP_MOD: return (s == 0) ? d : 32'($signed(d) % $signed(s));
      OP_AND: return d & s;
      OP_OR: return d | s;
      OP_XOR: return d ^ s;
      OP_NOT: return ~s;
      OP_LOAD, OP_SWAP: return s;
      default: return d;
    endcase
  endfunction : alu
  task automatic ld(input logic [31:0] a, x);
    @(negedge clk);
    acc_we = 1'b1;
    x_we = 1'b1;
    acc_wd = a;
    x_wd = x;
    @(negedge clk);
    acc_we = 1'b0;
    x_we = 1'b0;
  endtask : ld
  // one frame out, nine bytes back; value field always nonzero
  task automatic do_frame(input logic [7:0] c, t, ix, ds, st, input bit slow);
    logic [71:0] r, e;
    u_calc_host_model.send(mkf(MODULE_ADDR, c, t, ix, 32'h5a5a_0ff0, ds));
    u_calc_host_model.recv(slow, r);
    if (u_calc_host_model.tmo) begin
      n_fail++;
      test_done();
    end
    e = mkf(HOST_ADDR, MODULE_ADDR, st, c, 32'h0, 8'h00);
    chk_frame("reply", e, r);
  endtask : do_frame
  task automatic chk_var(input logic [7:0] ix, input logic [31:0] e);
    @(negedge clk);
    var_idx = ix;
    @(negedge clk);
    chk_word("variable", e, var_data);
  endtask : chk_var
  ////////////////////////////////////////////////////////////////////////////
  task automatic sc_reset;
    chk_word("acc", 32'h0, acc);
    chk_word("xreg", 32'h0, xreg);
    chk_bit("ready", 1'b1, rx_ready);
    chk_bit("reply valid", 1'b0, tx_valid);
  endtask : sc_reset
  // every type of all three codes, boundary indexes 0x00 and 0xff
  task automatic sc_ops;
    logic [7:0] c, ix;
    logic [31:0] d, s, r, v, a, x, e;
    v = 32'hffff_ff9c;
    a = 32'h0000_0007;
    x = 32'hffff_fffd;
    for (int k = 0; k < 3; k++) begin
      c = CMD_VAR_ACC + 8'(k);
      ix = (k == 1) ? 8'hff : (k == 2) ? 8'h00 : 8'h1b;
      for (int t = 0; t < 12; t++) begin
        ld(v, x);
        do_frame(CMD_VAR_ACC, 8'h09, ix, 8'h00, ST_OK, 1'b0);
        ld(a, x);
        do_frame(c, 8'(t), ix, 8'h00, ST_OK, t[0]);
        d = (k == 1) ? a : v;
        s = (k == 0) ? a : (k == 1) ? v : x;
        r = alu(4'(t), d, s);
        if (t == 11) begin
          chk_bit("equal", d == s, cmp_eq);
          chk_bit("less", $signed(d) < $signed(s), cmp_lt);
        end
        if (t == 10) s = d;
        e = (k == 1) ? r : (k == 0) ? s : a;
        chk_word("acc", e, acc);
        e = (k == 2) ? s : x;
        chk_word("xreg", e, xreg);
        e = (k == 1) ? s : r;
        chk_var(ix, e);
      end
    end
  endtask : sc_ops
  // equal compare, refusals, zero divisor, foreign address; slow sink
  task automatic sc_errors;
    logic [71:0] f;
    ld(32'hffff_ff9c, 32'h0);
    do_frame(CMD_ACC_VAR, 8'h0b, 8'h1b, 8'h00, ST_OK, 1'b0);
    chk_bit("equal", 1'b1, cmp_eq);
    do_frame(CMD_ACC_VAR, 8'h00, 8'h1b, 8'h01, ST_BAD_SUM, 1'b1);
    do_frame(8'h28, 8'h00, 8'h1b, 8'h00, ST_BAD_CMD, 1'b1);
    do_frame(CMD_ACC_VAR, 8'h0c, 8'h1b, 8'h00, ST_BAD_TYPE, 1'b1);
    do_frame(CMD_VAR_X, 8'h03, 8'h00, 8'h00, ST_OK, 1'b1);
    chk_var(8'h00, 32'hffff_ff9c);
    f = mkf(8'h05, CMD_ACC_VAR, 8'h00, 8'h1b, 32'h0, 8'h00);
    u_calc_host_model.send(f);
    repeat (3) @(negedge clk);
    chk_bit("reply valid", 1'b0, tx_valid);
    chk_bit("ready", 1'b1, rx_ready);
    chk_word("acc", 32'hffff_ff9c, acc);
  endtask : sc_errors
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    test_done();
  end
  initial begin
    repeat (2) @(negedge clk);
    sc_reset();
    repeat (2) @(negedge clk);
    rst = 1'b0;
    sc_ops();
    sc_errors();
    test_done();
  end
endmodule : variable_accumulator_alu_ops_tb_top
bind calc_exec_top calc_exec_top_assertions u_calc_exec_top_assertions (
  .I_MCLK(I_MCLK), .I_RST(I_RST), .O_RX_READY(O_RX_READY),
  .O_TX_DATA(O_TX_DATA), .O_TX_VALID(O_TX_VALID), .I_TX_READY(I_TX_READY),
  .I_ACC_WE(I_ACC_WE), .I_ACC_WDATA(I_ACC_WDATA), .I_X_WE(I_X_WE),
  .I_X_WDATA(I_X_WDATA), .O_ACC(O_ACC), .O_XREG(O_XREG),
  .O_CMP_EQ(O_CMP_EQ), .O_CMP_LT(O_CMP_LT)
);
